// [hdl/dcpwm_regs.svh]
/*
 * Register map, reset values and timing counts of the dual-channel PWM unit.
 * Assumes inclusion by bare name from the design modules and the testbench.
 */
`ifndef DCPWM_REGS_SVH
`define DCPWM_REGS_SVH

// Printed offsets are register indexes; byte address is four times the index.
`define DCPWM_IDX_CH0_DUTY   8'hfc
`define DCPWM_IDX_CH1_DUTY   8'hfd
`define DCPWM_IDX_PRESCALER  8'hfe
`define DCPWM_IDX_STATUS     8'hff
`define DCPWM_ADDR_CH0_DUTY  12'h3f0
`define DCPWM_ADDR_CH1_DUTY  12'h3f4
`define DCPWM_ADDR_PRESCALER 12'h3f8
`define DCPWM_ADDR_STATUS    12'h3fc

// Register reset values.
`define DCPWM_RST_DUTY       8'h00
`define DCPWM_RST_PRESCALER  8'h00

// Counter range: the counter wraps after this value and never holds 8'hff.
`define DCPWM_CNT_LAST       8'hfe
`define DCPWM_CNT_ZERO       8'h00
`define DCPWM_PRE_ZERO       9'h000

// AXI response codes.
`define DCPWM_RESP_OKAY      2'b00
`define DCPWM_RESP_SLVERR    2'b10

`endif

// [hdl/dcpwm_pkg.sv]
/*
 * Types shared by the dual-channel PWM unit.
 * Uses nothing from the register header.
 */
package dcpwm_pkg;
  typedef logic [7:0]  dcpwm_byte_t;
  typedef logic [11:0] dcpwm_addr_t;
  typedef logic [31:0] dcpwm_word_t;
  typedef logic [1:0]  dcpwm_resp_t;
endpackage

// [hdl/dcpwm_timebase.sv]
/*
 * Shared prescaler and modulo-255 counter of the PWM unit.
 * Assumes a single system clock and a synchronous active-low reset.
 */
`include "dcpwm_regs.svh"

module dcpwm_timebase
  import dcpwm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire dcpwm_pkg::dcpwm_byte_t reload,
  output      dcpwm_pkg::dcpwm_byte_t count
);

  logic [8:0]  pre_r;
  logic [8:0]  pre_last;
  logic        step;
  dcpwm_byte_t count_r;

  ////////////////////////////////////////////////////////////////////////////
  // The counter steps once every 2*(reload+1) clocks, so the last prescale
  // state is 2*reload+1; the extra halving matches the documented rate.
  assign pre_last = {reload, 1'b1};
  assign step     = (pre_r >= pre_last);

  // Prescaler; pre_r is internal and never reaches the register file.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_r <= `DCPWM_PRE_ZERO;
    end else if (step) begin
      pre_r <= `DCPWM_PRE_ZERO;
    end else begin
      pre_r <= pre_r + 9'h001;
    end
  end

  // One counter for both channels keeps them in period and phase.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_r <= `DCPWM_CNT_ZERO;
    end else if (step) begin
      if (count_r >= `DCPWM_CNT_LAST) begin
        count_r <= `DCPWM_CNT_ZERO;
      end else begin
        count_r <= count_r + 8'h01;
      end
    end
  end

  assign count = count_r;

endmodule

// [hdl/dcpwm_unit.sv]
/*
 * Dual-channel PWM unit with an AXI4-Lite register slave.
 * Assumes one 20 MHz clock, synchronous active-low reset, a well-behaved
 * AXI4-Lite master, and external filtering or a driver stage on the outputs.
 */
// Decided for this implementation: register access over AXI4-Lite.
`include "dcpwm_regs.svh"

// Overview of operation
// - Shared counter is clocked by a 9-bit prescaler reloaded from its register.
// - One prescaler and one counter serve both channels alike.
// - Prescaler divides by reload value plus one, factors 1 to 256.
// - Counter runs 0 to 254 then wraps, never holding 255.
// - Output low while duty register exceeds counter.
// - Output high while duty register is at or below counter.
// - Duty 00 gives constant high, FF gives constant low.
// - A new duty value acts on the output one clock after it is written.
// - Prescaler register reads back its reload value, never the live count.
// - Counter advances once every two times the factor clocks.
module dcpwm_unit
  import dcpwm_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire dcpwm_pkg::dcpwm_addr_t  s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output      logic                    s_axi_awready,
  input  wire dcpwm_pkg::dcpwm_word_t  s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output      logic                    s_axi_wready,
  output      dcpwm_pkg::dcpwm_resp_t  s_axi_bresp,
  output      logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire dcpwm_pkg::dcpwm_addr_t  s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output      logic                    s_axi_arready,
  output      dcpwm_pkg::dcpwm_word_t  s_axi_rdata,
  output      dcpwm_pkg::dcpwm_resp_t  s_axi_rresp,
  output      logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output      logic                    channel_output0,
  output      logic                    channel_output1
);

  dcpwm_byte_t ch0_duty_r;
  dcpwm_byte_t ch1_duty_r;
  dcpwm_byte_t prescaler_r;
  dcpwm_byte_t count;
  logic        aw_held_r;
  dcpwm_addr_t aw_addr_r;
  logic        w_held_r;
  dcpwm_word_t w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  dcpwm_resp_t bresp_r;
  logic        rvalid_r;
  dcpwm_word_t rdata_r;
  dcpwm_resp_t rresp_r;
  logic        do_write;
  logic        do_read;
  logic        out0_r;
  logic        out1_r;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by reads and writes; low two bits are ignored.
  function automatic logic [2:0] decode(input dcpwm_addr_t a);
    logic [2:0] sel;
    sel = 3'd0;
    case ({a[11:2], 2'b00})
      `DCPWM_ADDR_CH0_DUTY:  sel = 3'd1;
      `DCPWM_ADDR_CH1_DUTY:  sel = 3'd2;
      `DCPWM_ADDR_PRESCALER: sel = 3'd3;
      `DCPWM_ADDR_STATUS:    sel = 3'd4;
      default:               sel = 3'd0;
    endcase
    return sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write channels are taken independently and held until both are present.
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign do_write      = aw_held_r && w_held_r && !bvalid_r;

  // Write address holding register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  // Write data holding register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // Register file; only byte lane 0 carries data, a cleared lane leaves it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ch0_duty_r  <= `DCPWM_RST_DUTY;
      ch1_duty_r  <= `DCPWM_RST_DUTY;
      prescaler_r <= `DCPWM_RST_PRESCALER;
    end else if (do_write && w_strb_r[0]) begin
      case (decode(aw_addr_r))
        3'd1:    ch0_duty_r  <= w_data_r[7:0];
        3'd2:    ch1_duty_r  <= w_data_r[7:0];
        3'd3:    prescaler_r <= w_data_r[7:0];
        default: ch0_duty_r  <= ch0_duty_r;
      endcase
    end
  end

  // Write response; status register is read only, so writing it errs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `DCPWM_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      case (decode(aw_addr_r))
        3'd1, 3'd2, 3'd3: bresp_r <= `DCPWM_RESP_OKAY;
        default:          bresp_r <= `DCPWM_RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, answered one cycle after acceptance.
  assign s_axi_arready = !rvalid_r;
  assign do_read       = s_axi_arvalid && !rvalid_r;

  // Read data; the prescaler reads its reload value, never the live count.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `DCPWM_RESP_OKAY;
    end else if (do_read) begin
      rvalid_r <= 1'b1;
      rresp_r  <= `DCPWM_RESP_OKAY;
      case (decode(s_axi_araddr))
        3'd1:    rdata_r <= {24'h000000, ch0_duty_r};
        3'd2:    rdata_r <= {24'h000000, ch1_duty_r};
        3'd3:    rdata_r <= {24'h000000, prescaler_r};
        3'd4:    rdata_r <= {22'h000000, out1_r, out0_r, count};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= `DCPWM_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Shared timebase for both channels.
  dcpwm_timebase u_timebase (
    .clk    (clk),
    .rst_n  (rst_n),
    .reload (prescaler_r),
    .count  (count)
  );

  // Compare stage; registered so the pins are glitch free, costing one clock
  // of latency after a duty write or a counter step.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out0_r <= 1'b1;
      out1_r <= 1'b1;
    end else begin
      out0_r <= !(ch0_duty_r > count);
      out1_r <= !(ch1_duty_r > count);
    end
  end

  assign channel_output0 = out0_r;
  assign channel_output1 = out1_r;

endmodule

// [tb/dcpwm_load.sv]
/* Far-side load: integrates both PWM pins by counting their low cycles.
   Assumes the pins are sampled on the bench clock. */
module dcpwm_load (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic pin0,
  input  wire logic pin1,
  output int        low0,
  output int        low1
);
  timeunit 1ns;
  timeprecision 1ns;
  // A go pulse empties the integrators, like discharging a filter capacitor.
  always @(posedge clk) begin
    if (go) begin
      low0 <= 0;
      low1 <= 0;
    end else begin
      low0 <= low0 + int'(!pin0);
      low1 <= low1 + int'(!pin1);
    end
  end
endmodule

// [tb/dcpwm_unit_props.sv]
/* Port checks of the PWM unit.
   Assumes it is bound to dcpwm_unit and sees only its ports. */
module dcpwm_unit_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic channel_output0,
  input wire logic channel_output1
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  rd_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
    else $error("read answer without request");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  b_fall_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready || !rst_n))
    else $error("write answer left early");
  rst_out_a: assert property ($rose(rst_n) |-> channel_output0 && channel_output1)
    else $error("outputs not high after reset");
endmodule
bind dcpwm_unit dcpwm_unit_props props_i (.clk(clk), .rst_n(rst_n),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .channel_output0(channel_output0), .channel_output1(channel_output1));

// [tb/testbench.sv]
/* Self-checking bench of the PWM unit: reset values, registers, duty cycles.
   Assumes design, package, header, load model and checker compile first. */
`include "dcpwm_regs.svh"
module testbench;
  import dcpwm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0, rst_n = 1'h0, go = 1'h0;
  logic        awv = 1'h0, wv = 1'h0, bdy = 1'h0, arv = 1'h0, rdy = 1'h0;
  logic        awr, wr_r, bv, arr, rv, o0, o1;
  dcpwm_addr_t aw = 12'h000, ar = 12'h000;
  dcpwm_word_t wd = 32'h0, rd;
  dcpwm_resp_t br, rr;
  dcpwm_byte_t p, d, tbl[4] = '{8'h00, 8'hff, 8'h01, 8'hfe};
  logic [7:0]  seed = 8'h2c;
  logic [33:0] exp_q[$];
  int          bad_count = 0, check_count = 0, low0, low1, cyc = 0;
  dcpwm_unit uut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(aw), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bdy), .s_axi_araddr(ar), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rdy), .channel_output0(o0), .channel_output1(o1));
  dcpwm_load load_i (.clk(clk), .go(go), .pin0(o0), .pin1(o1), .low0(low0), .low1(low1));
  always #25 clk = ~clk;
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(logic [33:0] got, logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Each channel is released at its own handshake edge, bready at bvalid.
  // A settling edge after each transfer keeps back-to-back calls from
  // driving one signal twice within a single time step.
  task automatic wr(dcpwm_addr_t a, dcpwm_byte_t v, dcpwm_resp_t er = `DCPWM_RESP_OKAY);
    aw <= a;
    wd <= {24'h0, v};
    awv <= 1'h1;
    wv <= 1'h1;
    bdy <= 1'h1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wr_r) wv <= 1'h0;
      if (bv && bdy) begin
        bdy <= 1'h0;
        chk(34'(br), 34'(er));
      end
    end while (awv || wv || bdy);
    @(posedge clk);
  endtask
  task automatic rd_reg(dcpwm_addr_t a, logic [33:0] exp);
    exp_q.push_back(exp);
    ar <= a;
    arv <= 1'h1;
    rdy <= 1'h1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
      if (rv) rdy <= 1'h0;
    end while (arv || rdy);
    @(posedge clk);
  endtask
  // Low time over one full period must be duty times two prescaler factors.
  task automatic pwm(dcpwm_byte_t d0, dcpwm_byte_t d1);
    wr(`DCPWM_ADDR_CH0_DUTY, d0);
    wr(`DCPWM_ADDR_CH1_DUTY, d1);
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (510 * (p + 1) + 1) @(posedge clk);
    chk(34'(low0), 34'(d0 * 2 * (p + 1)));
    chk(34'(low1), 34'(d1 * 2 * (p + 1)));
  endtask
  // The oldest note is taken whenever a read answer is accepted.
  always @(posedge clk) begin
    if (rv && rdy) chk({rr, rd}, exp_q.pop_front());
  end
  // A hang ends the run as a mismatch.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    chk(34'({o1, o0}), 34'h3);
    rd_reg(`DCPWM_ADDR_CH0_DUTY, 34'h0);
    rd_reg(`DCPWM_ADDR_PRESCALER, 34'h0);
    rd_reg(12'h000, {`DCPWM_RESP_SLVERR, 32'h0});
    wr(`DCPWM_ADDR_STATUS, 8'h5a, `DCPWM_RESP_SLVERR);
    rd_reg(`DCPWM_ADDR_CH0_DUTY, 34'h0);
    seed = lfsr(seed);
    p = {6'h0, seed[1:0]};
    wr(`DCPWM_ADDR_PRESCALER, p);
    rd_reg(`DCPWM_ADDR_PRESCALER, {26'h0, p});
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      d = (i < 4) ? tbl[i] : seed;
      pwm(d, ~d);
    end
    wr(`DCPWM_ADDR_CH0_DUTY, 8'hff);
    @(posedge clk);
    chk(34'(o0), 34'h0);
    wr(`DCPWM_ADDR_CH0_DUTY, 8'h00);
    @(posedge clk);
    chk(34'(o0), 34'h1);
    stop_test();
  end
endmodule
